// ---- hdl/ufb_baud_gen.sv ----
`timescale 1ns/1ps
`include "ufb_cfg.svh"
module ufb_baud_gen #(
	parameter int RELOAD_W = 11
) (
	input  wire logic core_clk_in,
	input  wire logic rst_n_in,
	ufb_baud_if.gen   bif
);
	import ufb_pkg::*;

	logic [2:0]          m2_cnt;
	logic [6:0]          pre_cnt;
	logic [7:0]          frac_acc;
	logic [RELOAD_W-1:0] rld_cnt;
	logic                samp_tick;

	wire [2:0]  m2_last   = bif.div32_sel ? `UFB_M2_DIV32 : `UFB_M2_DIV64;
	wire        m2_tick   = (m2_cnt == m2_last);
	wire [6:0]  pre_last  = 7'((8'h01 << bif.baud_prescale_sel) - 8'h01);
	wire        pre_tick  = bif.brg_run && (pre_cnt == pre_last);
	wire [8:0]  frac_sum  = {1'b0, frac_acc} + {1'b0, bif.frac_step};
	// fractional step: carry of the phase accumulator gates the reload counter
	wire        brg_en    = bif.frac_en ? (pre_tick && frac_sum[8]) : pre_tick;
	wire        brg_uflow = brg_en && (rld_cnt == '0);
	wire        var_tick  = bif.src_timer1 ? bif.timer1_ovf : brg_uflow;
	wire        next_tick = (bif.mode == UFB_MODE_9FIX) ? m2_tick : var_tick;

	assign bif.samp_tick = samp_tick;

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			m2_cnt    <= 3'h0;
			pre_cnt   <= 7'h00;
			frac_acc  <= 8'h00;
			rld_cnt   <= '0;
			samp_tick <= 1'b0;
		end else begin
			m2_cnt    <= m2_tick ? 3'h0 : 3'(m2_cnt + 3'h1);
			samp_tick <= next_tick;
			if (!bif.brg_run)
				pre_cnt <= 7'h00;
			else
				pre_cnt <= pre_tick ? 7'h00 : 7'(pre_cnt + 7'h01);
			if (pre_tick && bif.frac_en)
				frac_acc <= frac_sum[7:0];
			// period is reload field plus one
			if (!bif.brg_run)
				rld_cnt <= bif.baud_reload_count;
			else if (brg_en)
				rld_cnt <= brg_uflow ? bif.baud_reload_count : RELOAD_W'(rld_cnt - 1'b1);
		end
	end
endmodule // ufb_baud_gen

// ---- hdl/ufb_top.sv ----
`timescale 1ns/1ps
`include "ufb_cfg.svh"
// Notes on behaviour
// - transmitter and receiver run on separate state machines so both directions move at once in modes one to three; mode zero runs one direction at a time.
// - a new frame is shifted in while the buffer still holds an unread byte; if still unread at its end, the new one is dropped.
// - frames carry eight or nine data bits, least significant first, both ways.
// - serial data leaves on the transmit line and is sampled from the receive line.
// - mode zero is an eight-bit shift register at half the peripheral clock.
// - mode one moves eight-bit asynchronous frames at the variable rate.
// - mode two moves nine-bit frames at one thirty-second or one sixty-fourth of the clock.
// - mode three moves nine-bit frames at the variable rate.
// - the variable rate is the generator underflow or the timer overflow, as selected.
// - the generator has a power-of-two prescale, a reload of field plus one and a fractional step.
// - completion of a sent frame and of a received frame that is kept in the buffer each raise a request flag.
module ufb_top #(
	parameter int RELOAD_W = 11
) (
	input  wire logic                 core_clk_in,
	input  wire logic                 rst_n_in,
	input  wire ufb_pkg::ufb_mode_e   mode_in,
	input  wire logic                 div32_sel_in,
	input  wire logic                 src_timer1_in,
	input  wire logic                 timer1_ovf_in,
	input  wire logic                 brg_run_in,
	input  wire logic                 frac_en_in,
	input  wire logic [2:0]           baud_prescale_sel_in,
	input  wire logic [RELOAD_W-1:0]  baud_reload_count_in,
	input  wire logic [7:0]           frac_step_in,
	input  wire logic                 multiproc_en_in,
	input  wire logic                 rx_en_in,
	input  wire logic [7:0]           tx_data_in,
	input  wire logic                 tx_bit9_in,
	input  wire logic                 tx_start_in,
	input  wire logic                 rx_read_in,
	input  wire logic                 tx_irq_clr_in,
	input  wire logic                 rx_irq_clr_in,
	input  wire logic                 rxd_in,
	output logic                      txd_out,
	output logic                      shift_clk_out,
	output logic [7:0]                rx_data_out,
	output logic                      rx_bit9_out,
	output logic                      rx_full_out,
	output logic                      rx_overrun_out,
	output logic                      tx_busy_out,
	output logic                      tx_irq_out,
	output logic                      rx_irq_out
);
	import ufb_pkg::*;

	ufb_baud_if #(.RELOAD_W(RELOAD_W)) bif ();

	assign bif.mode              = mode_in;
	assign bif.div32_sel         = div32_sel_in;
	assign bif.src_timer1        = src_timer1_in;
	assign bif.timer1_ovf        = timer1_ovf_in;
	assign bif.brg_run           = brg_run_in;
	assign bif.frac_en           = frac_en_in;
	assign bif.baud_prescale_sel = baud_prescale_sel_in;
	assign bif.baud_reload_count = baud_reload_count_in;
	assign bif.frac_step         = frac_step_in;

	ufb_baud_gen #(.RELOAD_W(RELOAD_W)) ufb_baud_gen_i (
		.core_clk_in (core_clk_in),
		.rst_n_in    (rst_n_in),
		.bif         (bif.gen)
	);

	ufb_tx_state_e                tx_state;
	ufb_rx_state_e                rx_state;
	logic [8:0]                   tx_sh;
	logic [7:0]                   rx_sh;
	logic [`UFB_SAMP_W-1:0]       tx_samp;
	logic [`UFB_SAMP_W-1:0]       rx_samp;
	logic [3:0]                   tx_bits;
	logic [3:0]                   rx_bits;
	logic                         rx_nine;
	logic                         m0_phase;

	wire samp_tick  = bif.samp_tick;
	wire mode_shift = (mode_in == UFB_MODE_SHIFT);
	wire nine_bit   = mode_in[1];
	wire tx_active  = (tx_state != UFB_TX_IDLE);
	wire rx_active  = (rx_state != UFB_RX_IDLE);
	wire m0_active  = mode_shift && (tx_active || rx_active);
	// mode zero bit: two clocks, the data moves on the second
	wire m0_end     = m0_active && m0_phase;
	wire tx_bit_end = mode_shift ? m0_end : (samp_tick && tx_samp == `UFB_SAMP_LAST);
	wire rx_bit_end = mode_shift ? m0_end : (samp_tick && rx_samp == `UFB_SAMP_LAST);
	wire rx_mid     = samp_tick && rx_samp == `UFB_SAMP_MID;
	wire tx_last    = (tx_bits == `UFB_BITS_LAST);
	wire rx_last    = (rx_bits == `UFB_BITS_LAST);
	wire tx_done    = tx_bit_end && ((tx_state == UFB_TX_STOP)
		|| (mode_shift && tx_state == UFB_TX_DATA && tx_last));
	// mode zero reception is armed by enable with the request flag clear
	wire rx_m0_go   = mode_shift && rx_en_in && !rx_irq_out && !tx_active && !tx_start_in;
	wire rx_go      = !mode_shift && rx_en_in && !rxd_in;
	wire rx_m0_done = mode_shift && rx_state == UFB_RX_DATA && rx_last && m0_end;
	wire rx_a_done  = !mode_shift && rx_state == UFB_RX_STOP && rx_mid;
	wire rx_done    = rx_m0_done || rx_a_done;
	wire [7:0] rx_word  = rx_m0_done ? {rxd_in, rx_sh[7:1]} : rx_sh;
	wire       rx_b9    = mode_shift ? 1'b0 : (nine_bit ? rx_nine : rxd_in);
	wire       mp_block = nine_bit && multiproc_en_in && !rx_b9;
	// earlier unread byte is kept, the new one is dropped
	wire rx_lost    = rx_done && rx_full_out && !rx_read_in;
	wire rx_accept  = rx_done && !mp_block && !rx_lost;

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			m0_phase      <= 1'b0;
			shift_clk_out <= `UFB_SCLK_IDLE;
		end else begin
			m0_phase      <= m0_active ? !m0_phase : 1'b0;
			// one clock behind the phase; high half then low half
			shift_clk_out <= m0_active ? m0_phase : `UFB_SCLK_IDLE;
		end
	end

	// transmitter
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tx_state    <= UFB_TX_IDLE;
			tx_sh       <= 9'h000;
			tx_samp     <= '0;
			tx_bits     <= 4'h0;
			txd_out     <= `UFB_TXD_IDLE;
			tx_busy_out <= 1'b0;
		end else begin
			tx_samp <= (!tx_active || tx_bit_end) ? '0 : (samp_tick ? tx_samp + `UFB_SAMP_ONE : tx_samp);
			case (tx_state)
				UFB_TX_IDLE: begin
					txd_out <= `UFB_TXD_IDLE;
					if (tx_start_in && !rx_active) begin
						tx_sh       <= {tx_bit9_in, tx_data_in};
						tx_bits     <= 4'h0;
						tx_busy_out <= 1'b1;
						if (mode_shift) begin
							tx_state <= UFB_TX_DATA;
							txd_out  <= tx_data_in[0];
						end else begin
							tx_state <= UFB_TX_START;
							txd_out  <= 1'b0;
						end
					end else if (tx_start_in && !mode_shift) begin
						tx_sh       <= {tx_bit9_in, tx_data_in};
						tx_bits     <= 4'h0;
						tx_busy_out <= 1'b1;
						tx_state    <= UFB_TX_START;
						txd_out     <= 1'b0;
					end
				end
				UFB_TX_START: begin
					if (tx_bit_end) begin
						tx_state <= UFB_TX_DATA;
						txd_out  <= tx_sh[0];
					end
				end
				UFB_TX_DATA: begin
					if (tx_bit_end) begin
						tx_bits <= tx_bits + 4'h1;
						if (!tx_last) begin
							tx_sh   <= {1'b0, tx_sh[8:1]};
							txd_out <= tx_sh[1];
						end else if (mode_shift) begin
							tx_state    <= UFB_TX_IDLE;
							txd_out     <= `UFB_TXD_IDLE;
							tx_busy_out <= 1'b0;
						end else if (nine_bit) begin
							// after seven shifts the ninth bit sits at bit one
							tx_state <= UFB_TX_BIT9;
							txd_out  <= tx_sh[1];
						end else begin
							tx_state <= UFB_TX_STOP;
							txd_out  <= 1'b1;
						end
					end
				end
				UFB_TX_BIT9: begin
					if (tx_bit_end) begin
						tx_state <= UFB_TX_STOP;
						txd_out  <= 1'b1;
					end
				end
				UFB_TX_STOP: begin
					if (tx_bit_end) begin
						tx_state    <= UFB_TX_IDLE;
						tx_busy_out <= 1'b0;
					end
				end
				default: begin
					tx_state <= UFB_TX_IDLE;
				end
			endcase
		end
	end

	// receiver
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rx_state <= UFB_RX_IDLE;
			rx_sh    <= `UFB_BYTE_RST;
			rx_samp  <= '0;
			rx_bits  <= 4'h0;
			rx_nine  <= 1'b0;
		end else begin
			rx_samp <= (!rx_active || rx_bit_end) ? '0 : (samp_tick ? rx_samp + `UFB_SAMP_ONE : rx_samp);
			case (rx_state)
				UFB_RX_IDLE: begin
					rx_bits <= 4'h0;
					if (rx_m0_go)
						rx_state <= UFB_RX_DATA;
					else if (rx_go)
						rx_state <= UFB_RX_START;
				end
				UFB_RX_START: begin
					// start bit that is high again at mid-bit was a glitch
					if (rx_mid && rxd_in)
						rx_state <= UFB_RX_IDLE;
					else if (rx_bit_end)
						rx_state <= UFB_RX_DATA;
				end
				UFB_RX_DATA: begin
					if ((mode_shift && m0_end) || (!mode_shift && rx_mid)) begin
						rx_sh <= {rxd_in, rx_sh[7:1]};
						if (mode_shift && rx_last)
							rx_state <= UFB_RX_IDLE;
					end
					if (!mode_shift && rx_bit_end) begin
						rx_bits  <= rx_bits + 4'h1;
						if (rx_last)
							rx_state <= nine_bit ? UFB_RX_BIT9 : UFB_RX_STOP;
					end else if (mode_shift && m0_end) begin
						rx_bits <= rx_bits + 4'h1;
					end
				end
				UFB_RX_BIT9: begin
					if (rx_mid)
						rx_nine <= rxd_in;
					if (rx_bit_end)
						rx_state <= UFB_RX_STOP;
				end
				UFB_RX_STOP: begin
					// ending at mid stop bit leaves room for the next start edge
					if (rx_mid)
						rx_state <= UFB_RX_IDLE;
				end
				default: begin
					rx_state <= UFB_RX_IDLE;
				end
			endcase
		end
	end

	// buffer and request flags; a setting event beats a same-cycle clear
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rx_data_out    <= `UFB_BYTE_RST;
			rx_bit9_out    <= 1'b0;
			rx_full_out    <= 1'b0;
			rx_overrun_out <= 1'b0;
			tx_irq_out     <= 1'b0;
			rx_irq_out     <= 1'b0;
		end else begin
			if (rx_accept) begin
				rx_data_out <= rx_word;
				rx_bit9_out <= rx_b9;
			end
			rx_full_out    <= rx_accept || (rx_full_out && !rx_read_in);
			rx_overrun_out <= rx_lost || rx_overrun_out && !rx_read_in;
			tx_irq_out     <= tx_done || (tx_irq_out && !tx_irq_clr_in);
			rx_irq_out     <= rx_accept || (rx_irq_out && !rx_irq_clr_in);
		end
	end
endmodule // ufb_top

// ---- pkg/ufb_baud_if.sv ----
`timescale 1ns/1ps
interface ufb_baud_if #(
	parameter int RELOAD_W = 11
);
	ufb_pkg::ufb_mode_e  mode;
	logic                div32_sel;
	logic                src_timer1;
	logic                timer1_ovf;
	logic                brg_run;
	logic                frac_en;
	logic [2:0]          baud_prescale_sel;
	logic [RELOAD_W-1:0] baud_reload_count;
	logic [7:0]          frac_step;
	logic                samp_tick;

	modport core (output mode, div32_sel, src_timer1, timer1_ovf, brg_run, frac_en,
		baud_prescale_sel, baud_reload_count, frac_step, input samp_tick);
	modport gen (input mode, div32_sel, src_timer1, timer1_ovf, brg_run, frac_en,
		baud_prescale_sel, baud_reload_count, frac_step, output samp_tick);
endinterface

// ---- pkg/ufb_cfg.svh ----
`ifndef UFB_CFG_SVH
`define UFB_CFG_SVH

// oversampling of one asynchronous bit
`define UFB_SAMP_W     4
`define UFB_SAMP_LAST  4'hF
`define UFB_SAMP_MID   4'h7
`define UFB_SAMP_ONE   4'h1
// mode 2 sample tick spacing in clocks: 16 samples x 2 = /32, 16 x 4 = /64
`define UFB_M2_DIV32   3'h1
`define UFB_M2_DIV64   3'h3
`define UFB_BITS_LAST  4'h7
`define UFB_TXD_IDLE   1'b1
`define UFB_SCLK_IDLE  1'b1
`define UFB_BYTE_RST   8'h00

`endif

// ---- pkg/ufb_pkg.sv ----
package ufb_pkg;
	typedef enum logic [1:0] {
		UFB_MODE_SHIFT = 2'b00,
		UFB_MODE_8BIT  = 2'b01,
		UFB_MODE_9FIX  = 2'b10,
		UFB_MODE_9VAR  = 2'b11
	} ufb_mode_e;

	typedef enum logic [2:0] {
		UFB_TX_IDLE  = 3'b000,
		UFB_TX_START = 3'b001,
		UFB_TX_DATA  = 3'b010,
		UFB_TX_BIT9  = 3'b011,
		UFB_TX_STOP  = 3'b100
	} ufb_tx_state_e;

	typedef enum logic [2:0] {
		UFB_RX_IDLE  = 3'b000,
		UFB_RX_START = 3'b001,
		UFB_RX_DATA  = 3'b010,
		UFB_RX_BIT9  = 3'b011,
		UFB_RX_STOP  = 3'b100
	} ufb_rx_state_e;
endpackage

// ---- sim/ufb_serial_peer.sv ----
`timescale 1ns/1ps
module ufb_serial_peer (
	input  wire logic       clk_in,
	input  wire logic       txd_in,
	input  wire logic       listen_in,
	input  wire logic [7:0] bit_clks_in,
	output logic            rxd_out,
	output logic [8:0]      word_out,
	output logic            word_stb_out
);
	initial begin
		rxd_out = 1'b1;
		word_stb_out = 1'b0;
		word_out = 9'h000;
	end

	// start low, data lsb first, stop high, then the line idles high
	task automatic send(input logic [8:0] w, input int nb);
		for (int i = -1; i <= nb; i++) begin
			@(posedge clk_in);
			rxd_out <= (i < 0) ? 1'b0 : (i == nb) ? 1'b1 : w[i];
			repeat (bit_clks_in - 1) @(posedge clk_in);
		end
	endtask

	// nine mid-bit samples; in eight-bit frames the ninth is the stop bit
	always begin
		@(negedge txd_in);
		if (listen_in) begin
			repeat (bit_clks_in / 2) @(posedge clk_in);
			for (int i = 0; i < 9; i++) begin
				repeat (bit_clks_in) @(posedge clk_in);
				word_out[i] <= txd_in;
			end
			word_stb_out <= 1'b1;
			@(posedge clk_in);
			word_stb_out <= 1'b0;
		end
	end
endmodule // ufb_serial_peer

// ---- sim/ufb_top_asserts.sv ----
`timescale 1ns/1ps
module ufb_top_asserts
	import ufb_pkg::*;
(
	input wire logic               core_clk_in,
	input wire logic               rst_n_in,
	input wire ufb_pkg::ufb_mode_e mode_in,
	input wire logic               rx_en_in,
	input wire logic               tx_start_in,
	input wire logic               rx_read_in,
	input wire logic               txd_out,
	input wire logic               shift_clk_out,
	input wire logic [7:0]         rx_data_out,
	input wire logic               rx_full_out,
	input wire logic               rx_overrun_out,
	input wire logic               tx_busy_out,
	input wire logic               tx_irq_out,
	input wire logic               rx_irq_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);

	property p_txd_idle; !tx_busy_out |-> txd_out; endproperty
	a_txd_idle: assert property (p_txd_idle) else $error("txd low while idle");
	property p_start_bit; tx_start_in && !tx_busy_out && mode_in != UFB_MODE_SHIFT |=> tx_busy_out && !txd_out; endproperty
	a_start_bit: assert property (p_start_bit) else $error("no start bit");
	property p_tx_irq; $fell(tx_busy_out) |=> tx_irq_out; endproperty
	a_tx_irq: assert property (p_tx_irq) else $error("no send request");
	// shift mode: eight bits of two clocks each
	property p_m0_len; tx_start_in && !tx_busy_out && mode_in == UFB_MODE_SHIFT && !rx_en_in
		|=> tx_busy_out[*8] ##1 tx_busy_out[*8] ##1 !tx_busy_out; endproperty
	a_m0_len: assert property (p_m0_len) else $error("shift frame length wrong");
	property p_m0_hold; mode_in == UFB_MODE_SHIFT && tx_busy_out && $changed(txd_out) |=> $stable(txd_out); endproperty
	a_m0_hold: assert property (p_m0_hold) else $error("shift bit too short");
	property p_sclk_idle; mode_in != UFB_MODE_SHIFT |-> shift_clk_out; endproperty
	a_sclk_idle: assert property (p_sclk_idle) else $error("shift clock moved");
	property p_rx_full; $rose(rx_irq_out) |-> rx_full_out; endproperty
	a_rx_full: assert property (p_rx_full) else $error("request without byte");
	property p_overrun; $rose(rx_overrun_out) |-> rx_full_out && $stable(rx_data_out); endproperty
	a_overrun: assert property (p_overrun) else $error("old byte overwritten");
	property p_read_clr; rx_read_in |=> !rx_overrun_out; endproperty
	a_read_clr: assert property (p_read_clr) else $error("overrun not cleared");
endmodule // ufb_top_asserts

// ---- sim/ufb_top_bench.sv ----
`timescale 1ns/1ps
module ufb_top_bench;
	import ufb_pkg::*;
	logic        core_clk_in = 1'b0;
	logic        timer1_ovf_in = 1'b0;
	logic        rst_n_in, div32_sel_in, src_timer1_in, brg_run_in, frac_en_in, multiproc_en_in, rx_en_in;
	logic        tx_bit9_in, tx_start_in, rx_read_in, tx_irq_clr_in, rx_irq_clr_in, rxd_in, listen, irq_seen;
	logic        txd_out, shift_clk_out, rx_bit9_out, rx_full_out, rx_overrun_out, tx_busy_out, tx_irq_out;
	logic        rx_irq_out, word_stb;
	logic [2:0]  baud_prescale_sel_in;
	logic [10:0] baud_reload_count_in;
	logic [7:0]  tx_data_in, frac_step_in, rx_data_out, bit_clks;
	logic [8:0]  word, w;
	logic [8:0]  rx_q[$], tx_q[$];
	ufb_mode_e   mode_in;
	int          fails = 0, checked = 0, seed = 32'h0000_b737;

	ufb_top ufb_top_i (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .mode_in(mode_in),
		.div32_sel_in(div32_sel_in), .src_timer1_in(src_timer1_in), .timer1_ovf_in(timer1_ovf_in),
		.brg_run_in(brg_run_in), .frac_en_in(frac_en_in), .baud_prescale_sel_in(baud_prescale_sel_in),
		.baud_reload_count_in(baud_reload_count_in), .frac_step_in(frac_step_in),
		.multiproc_en_in(multiproc_en_in), .rx_en_in(rx_en_in), .tx_data_in(tx_data_in),
		.tx_bit9_in(tx_bit9_in), .tx_start_in(tx_start_in), .rx_read_in(rx_read_in),
		.tx_irq_clr_in(tx_irq_clr_in), .rx_irq_clr_in(rx_irq_clr_in), .rxd_in(rxd_in), .txd_out(txd_out),
		.shift_clk_out(shift_clk_out), .rx_data_out(rx_data_out), .rx_bit9_out(rx_bit9_out),
		.rx_full_out(rx_full_out), .rx_overrun_out(rx_overrun_out), .tx_busy_out(tx_busy_out),
		.tx_irq_out(tx_irq_out), .rx_irq_out(rx_irq_out));
	ufb_serial_peer ufb_serial_peer_i (.clk_in(core_clk_in), .txd_in(txd_out), .listen_in(listen),
		.bit_clks_in(bit_clks), .rxd_out(rxd_in), .word_out(word), .word_stb_out(word_stb));

	initial forever #12.5 core_clk_in = ~core_clk_in;
	// overflow pulse every other clock, so a bit lasts 32 clocks
	always @(posedge core_clk_in) timer1_ovf_in <= ~timer1_ovf_in;

	task automatic summarize();
		if (fails == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic cmp(input logic [8:0] got, input logic [8:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("Error %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_in);
	endtask

	always @(posedge core_clk_in) begin
		irq_seen <= rx_irq_out;
		if (rx_irq_out === 1'b1 && irq_seen === 1'b0 && rx_q.size() > 0)
			cmp({rx_bit9_out, rx_data_out}, rx_q.pop_front());
		if (word_stb === 1'b1 && tx_q.size() > 0)
			cmp(word, tx_q.pop_front());
	end

	task automatic cfg(input ufb_mode_e m, input logic d32, input logic t1, input logic [2:0] ps,
		input logic fe, input logic [7:0] bc);
		@(posedge core_clk_in);
		mode_in <= m;
		{div32_sel_in, src_timer1_in, baud_prescale_sel_in, frac_en_in, bit_clks} <= {d32, t1, ps, fe, bc};
		listen <= (m != UFB_MODE_SHIFT);
		rx_en_in <= (m != UFB_MODE_SHIFT);
		tick(2);
	endtask

	task automatic finish(input logic rd);
		int n;
		n = 0;
		while (tx_busy_out !== 1'b0 && n < 1000) begin
			tick(1);
			n++;
		end
		cmp({8'h00, tx_busy_out}, 9'h000);
		tick(3);
		cmp({8'h00, tx_irq_out}, 9'h001);
		{tx_irq_clr_in, rx_irq_clr_in, rx_read_in} <= {2'b11, rd};
		tick(1);
		{tx_irq_clr_in, rx_irq_clr_in, rx_read_in} <= 3'b000;
		tick(1);
	endtask

	// send and receive at once; the sent frame is always checked, the received one only when exp_rx is set
	task automatic xfer(input logic [8:0] v, input int nb, input logic exp_rx, input logic rd);
		tx_q.push_back(v);
		if (exp_rx)
			rx_q.push_back(v);
		@(posedge core_clk_in);
		{tx_bit9_in, tx_data_in, tx_start_in} <= {v, 1'b1};
		tick(1);
		tx_start_in <= 1'b0;
		ufb_serial_peer_i.send(v, nb);
		finish(rd);
	endtask

	task automatic frames(input int nb);
		for (int i = 0; i < 2; i++) begin
			w = 9'($random(seed));
			if (nb == 8)
				w[8] = 1'b1;
			xfer(w, nb, 1'b1, 1'b1);
		end
	endtask

	initial begin
		{rst_n_in, div32_sel_in, src_timer1_in, frac_en_in, multiproc_en_in, tx_bit9_in, tx_start_in} = '0;
		{rx_read_in, tx_irq_clr_in, rx_irq_clr_in, listen, baud_prescale_sel_in, tx_data_in} = '0;
		{brg_run_in, rx_en_in, baud_reload_count_in, frac_step_in, bit_clks} = {2'b10, 11'h000, 8'h80, 8'h20};
		mode_in = UFB_MODE_SHIFT;
		tick(3);
		rst_n_in <= 1'b1;
		tick(1);
		cmp({txd_out, shift_clk_out, rx_full_out, rx_overrun_out, tx_busy_out, tx_irq_out, rx_irq_out,
			rx_bit9_out, |rx_data_out}, 9'h180);
		w = 9'($random(seed));
		tx_data_in <= w[7:0];
		tx_start_in <= 1'b1;
		tick(1);
		tx_start_in <= 1'b0;
		for (int k = 0; k < 16; k++) begin
			#1;
			cmp({7'h00, txd_out, shift_clk_out}, {7'h00, w[k / 2], ~k[0]});
			tick(1);
		end
		finish(1'b1);
		// shift mode receive: the idle line shifts in all ones
		rx_q.push_back(9'h0ff);
		rx_en_in <= 1'b1;
		tick(20);
		{rx_en_in, rx_irq_clr_in, rx_read_in} <= 3'b011;
		tick(1);
		{rx_irq_clr_in, rx_read_in} <= 2'b00;
		cfg(UFB_MODE_9FIX, 1'b1, 1'b0, 3'h0, 1'b0, 8'h20);
		frames(9);
		cfg(UFB_MODE_9FIX, 1'b0, 1'b0, 3'h0, 1'b0, 8'h40);
		frames(9);
		cfg(UFB_MODE_8BIT, 1'b0, 1'b1, 3'h0, 1'b0, 8'h20);
		frames(8);
		cfg(UFB_MODE_9VAR, 1'b0, 1'b0, 3'h1, 1'b0, 8'h20);
		frames(9);
		cfg(UFB_MODE_9VAR, 1'b0, 1'b0, 3'h0, 1'b1, 8'h20);
		frames(9);
		xfer(9'h1a5, 9, 1'b1, 1'b0);
		xfer(9'h05a, 9, 1'b0, 1'b0);
		cmp({rx_bit9_out, rx_data_out}, 9'h1a5);
		cmp({8'h00, rx_overrun_out}, 9'h001);
		multiproc_en_in <= 1'b1;
		rx_read_in <= 1'b1;
		tick(1);
		rx_read_in <= 1'b0;
		tick(1);
		cmp({7'h00, rx_overrun_out, rx_full_out}, 9'h000);
		xfer(9'h0c3, 9, 1'b0, 1'b0);
		cmp({8'h00, rx_full_out}, 9'h000);
		xfer(9'h13c, 9, 1'b1, 1'b1);
		cmp(9'(rx_q.size() + tx_q.size()), 9'h000);
		summarize();
	end

	// whole run is near 6000 clocks
	initial begin
		#600000;
		fails++;
		summarize();
	end
endmodule // ufb_top_bench

bind ufb_top ufb_top_asserts ufb_top_asserts_i (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
	.mode_in(mode_in), .rx_en_in(rx_en_in), .tx_start_in(tx_start_in), .rx_read_in(rx_read_in),
	.txd_out(txd_out), .shift_clk_out(shift_clk_out), .rx_data_out(rx_data_out), .rx_full_out(rx_full_out),
	.rx_overrun_out(rx_overrun_out), .tx_busy_out(tx_busy_out), .tx_irq_out(tx_irq_out),
	.rx_irq_out(rx_irq_out));
